// ===== core/hpsc_top.sv
// Purpose: host power and restart switch controller with host watchdog
// Assumes: classic Wishbone slave, one clock, asynchronous active-low reset
// Notes: commands arrive as packets written to the command register
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module hpsc_top
    import hpsc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // wishbone slave
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // host power sense and front keys
    input wire logic POWER_SENSE,
    input wire logic KEY_CONFIRM,
    input wire logic KEY_CANCEL,
    // restart line, open-drain style
    input wire logic RESTART_I,
    output logic RESTART_O,
    output logic RESTART_OE,
    // power control line, open-drain style
    input wire logic POWER_CTL_I,
    output logic POWER_CTL_O,
    output logic POWER_CTL_OE,
    // module side effects
    output logic DISPLAY_BLANK,
    output logic BACKLIGHT_OFF,
    output logic LEDS_OFF,
    output logic [1:0] MESSAGE,
    output logic SELF_RESTART
);

    hpsc_regs_s q;
    hpsc_regs_s n;
    logic sense;
    logic conf;
    logic canc;
    logic conf_long;
    logic conf_short;
    logic canc_long;
    logic plen_end;
    logic wd_fire;
    logic do_rst;
    logic req;
    logic cmd_ok;
    logic [7:0] c_type;
    logic [1:0] c_len;
    logic [7:0] c_d0;
    logic [7:0] c_d1;
    logic [4:0] agree;

    // next-state logic for the whole block
    always_comb begin
        n = q;
        do_rst = 1'b0;
        n.ack = 1'b0;
        n.self_rst = 1'b0;
        n.tick = 1'b0;
        // three-stage synchronisers, value taken once stages 2 and 3 agree
        n.s1 = {POWER_CTL_I, RESTART_I, KEY_CANCEL, KEY_CONFIRM, POWER_SENSE};
        n.s2 = q.s1;
        n.s3 = q.s2;
        agree = q.s2 ~^ q.s3;
        n.stab = (agree & q.s3) | (~agree & q.stab);
        sense = q.stab[IN_SENSE];
        conf = q.stab[IN_CONF];
        canc = q.stab[IN_CANC];
        n.sense_prev = sense;
        // base tick of 1/32 second
        if (q.tick_cnt == 20'(TICK_CYCLES - 1)) begin
            n.tick_cnt = 20'h00000;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 20'h00001;
        end
        // idle level of each line, learned while not driving
        if (!q.rst_oe) begin
            n.rst_idle = q.stab[IN_RSTL];
        end
        if (!q.pwr_oe) begin
            n.pwr_idle = q.stab[IN_PWRL];
        end
        // key hold timers, cleared on release
        if (!conf) begin
            n.conf_cnt = 9'h000;
        end else if (q.tick && q.conf_cnt != 9'h1FF) begin
            n.conf_cnt = q.conf_cnt + 9'h001;
        end
        if (!canc) begin
            n.canc_cnt = 9'h000;
        end else if (q.tick && q.canc_cnt != 9'h1FF) begin
            n.canc_cnt = q.canc_cnt + 9'h001;
        end
        conf_long = q.tick && conf && q.conf_cnt == HOLD_LONG_TK - 9'h001;
        conf_short = q.tick && conf && q.conf_cnt == HOLD_SHORT_TK - 9'h001;
        canc_long = q.tick && canc && q.canc_cnt == HOLD_LONG_TK - 9'h001;
        // pulse length counter
        if (q.tick && q.pcnt != 9'h1FF) begin
            n.pcnt = q.pcnt + 9'h001;
        end
        // configured power pulse end; code 255 waits for sense or 8 s
        if (q.plen == PLEN_HOLD) begin
            plen_end = sense != q.sense_at || q.pcnt == MAX_HOLD_TK;
        end else begin
            plen_end = q.pcnt >= {1'b0, q.plen};
        end
        // watchdog countdown in whole seconds
        wd_fire = q.wd_to != 8'h00 && q.wd_cnt == 8'h00;
        if (q.wd_to != 8'h00 && q.wd_cnt != 8'h00 && q.tick) begin
            n.wd_sub = q.wd_sub + 5'h01;
            if (q.wd_sub == 5'h1F) begin
                n.wd_cnt = q.wd_cnt - 8'h01;
            end
        end
        // pulse sequencer
        unique case (q.st)
            ST_IDLE: begin
                if (q.cfg[CFG_FOLLOW] && sense && !q.sense_prev) begin
                    do_rst = 1'b1;
                end else if (wd_fire) begin
                    n.st = ST_RSTP;
                    n.pcnt = 9'h000;
                end else if (q.cfg[CFG_KRST] && sense && conf_long) begin
                    n.st = ST_RSTP;
                    n.pcnt = 9'h000;
                end else if (q.cfg[CFG_KON] && !sense && conf_short) begin
                    n.st = ST_PONP;
                    n.pcnt = 9'h000;
                    n.sense_at = sense;
                end else if (q.cfg[CFG_KOFF] && sense && canc_long) begin
                    n.st = ST_POFFP;
                    n.pcnt = 9'h000;
                    n.sense_at = sense;
                end
            end
            ST_RSTP: begin
                if (q.pcnt == RST_PULSE_TK) begin
                    do_rst = 1'b1;
                end
            end
            ST_PONP: begin
                if (plen_end) begin
                    do_rst = 1'b1;
                end
            end
            ST_POFFP: begin
                if (plen_end && canc) begin
                    n.st = ST_POFFX;
                    n.pcnt = 9'h000;
                end else if (plen_end) begin
                    n.st = ST_IDLE;
                end
            end
            ST_POFFX: begin
                if (!canc || q.pcnt == EXT_HOLD_TK) begin
                    n.st = ST_IDLE;
                end
            end
        endcase
        // wishbone slave, one wait state then a one-cycle ack
        req = WB_CYC_I && WB_STB_I && !q.ack;
        n.ack = req;
        c_type = WB_DAT_I[7:0];
        c_len = WB_DAT_I[9:8];
        c_d0 = WB_DAT_I[23:16];
        c_d1 = WB_DAT_I[31:24];
        cmd_ok = req && WB_WE_I && WB_ADR_I == REG_CMD
            && WB_SEL_I == 4'hF && q.st != ST_RSTP;
        if (req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                REG_RESP: begin
                    n.rdat = {q.resp_d1, q.resp_d0, 5'h00, q.resp_vld,
                        q.resp_len, q.resp_type};
                    n.resp_vld = 1'b0;
                end
                REG_STAT: begin
                    n.rdat = {16'h0000, q.wd_cnt, canc, conf, sense, q.st};
                end
                default: begin
                    n.rdat = 32'h00000000;
                end
            endcase
        end
        if (req && WB_WE_I && WB_ADR_I == REG_CTRL && WB_SEL_I[0]
            && WB_DAT_I[0]) begin
            n.boot_cfg = q.cfg;
            n.boot_plen = q.plen;
        end
        // command interpreter
        if (cmd_ok) begin
            n.resp_vld = 1'b1;
            n.resp_len = 2'h0;
            n.resp_d0 = 8'h00;
            n.resp_d1 = 8'h00;
            if (c_type == CMD_ATX && c_len == 2'h0) begin
                n.resp_type = RSP_ATX;
                n.resp_len = 2'h2;
                n.resp_d0 = q.cfg;
                n.resp_d1 = q.plen;
            end else if (c_type == CMD_ATX && c_len != 2'h3) begin
                n.resp_type = RSP_ATX;
                n.cfg = c_d0;
                if (c_len == 2'h2) begin
                    n.plen = c_d1;
                end
            end else if (c_type == CMD_WDOG && c_len == 2'h0) begin
                n.resp_type = RSP_WDOG;
                n.resp_len = 2'h1;
                n.resp_d0 = q.wd_to;
            end else if (c_type == CMD_WDOG && c_len == 2'h1) begin
                n.resp_type = RSP_WDOG;
                n.wd_to = c_d0;
                n.wd_cnt = c_d0;
                n.wd_sub = 5'h00;
            end else begin
                n.resp_type = RSP_ERR | {2'h0, c_type[5:0]};
            end
        end
        // full restart, as on first power-up
        if (do_rst) begin
            n.st = ST_IDLE;
            n.cfg = q.boot_cfg;
            n.plen = q.boot_plen;
            n.wd_to = 8'h00;
            n.wd_cnt = 8'h00;
            n.wd_sub = 5'h00;
            n.resp_vld = 1'b0;
            n.self_rst = 1'b1;
        end
        // line drive follows the sequencer state
        n.rst_oe = n.st == ST_RSTP;
        n.pwr_oe = n.st == ST_PONP || n.st == ST_POFFP
            || n.st == ST_POFFX;
        n.rst_lvl = q.cfg[CFG_AUTO] ? !q.rst_idle : q.cfg[CFG_RINV];
        n.pwr_lvl = q.cfg[CFG_AUTO] ? !q.pwr_idle : q.cfg[CFG_PINV];
        // display and led blanking while the host is off
        n.blank = n.cfg[CFG_FOLLOW] && !sense;
        n.leds_off = n.cfg[CFG_FOLLOW] && n.cfg[CFG_LEDS] && !sense;
        // message shown during each pulse
        unique case (n.st)
            ST_RSTP: n.msg = MSG_RESTART;
            ST_PONP: n.msg = MSG_PWR_ON;
            ST_POFFP, ST_POFFX: n.msg = MSG_PWR_OFF;
            default: n.msg = MSG_NONE;
        endcase
    end

    // state register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.cfg <= BOOT_CFG_RST;
            q.boot_cfg <= BOOT_CFG_RST;
            q.plen <= PLEN_HOLD;
            q.boot_plen <= PLEN_HOLD;
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign WB_DAT_O = q.rdat;
    assign WB_ACK_O = q.ack;
    assign RESTART_O = q.rst_lvl;
    assign RESTART_OE = q.rst_oe;
    assign POWER_CTL_O = q.pwr_lvl;
    assign POWER_CTL_OE = q.pwr_oe;
    assign DISPLAY_BLANK = q.blank;
    assign BACKLIGHT_OFF = q.blank;
    assign LEDS_OFF = q.leds_off;
    assign MESSAGE = q.msg;
    assign SELF_RESTART = q.self_rst;

    // lines float whenever no pulse runs
    property p_idle_float;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.st == ST_IDLE |-> !RESTART_OE && !POWER_CTL_OE;
    endproperty
    a_idle_float: assert property (p_idle_float)
        else $error("line driven while idle");

    // fixed polarity drives the power line at the configured level
    property p_pol;
        @(posedge CLK_SYS) disable iff (!RST_N)
        $rose(POWER_CTL_OE) && !$past(q.cfg[CFG_AUTO])
            |-> POWER_CTL_O == $past(q.cfg[CFG_PINV]);
    endproperty
    a_pol: assert property (p_pol)
        else $error("power line at wrong level");

    // restart pulse never drops in its first cycles
    property p_rst_len;
        @(posedge CLK_SYS) disable iff (!RST_N)
        $rose(RESTART_OE) |-> RESTART_OE [*8];
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("restart pulse shape wrong");

    // pulse counter at one second ends the pulse and restarts
    property p_rst_end;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.st == ST_RSTP && q.pcnt == RST_PULSE_TK
            |=> SELF_RESTART && !RESTART_OE;
    endproperty
    a_rst_end: assert property (p_rst_end)
        else $error("restart pulse did not end at one second");

    // no answer appears during a restart pulse
    property p_no_cmd;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.st == ST_RSTP && !q.resp_vld |=> !q.resp_vld;
    endproperty
    a_no_cmd: assert property (p_no_cmd)
        else $error("command served during restart");

    // extension never passes five seconds
    property p_ext;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.st == ST_POFFX |-> q.pcnt <= EXT_HOLD_TK;
    endproperty
    a_ext: assert property (p_ext)
        else $error("power off extension too long");

    // leds go dark only with follow-host
    property p_leds;
        @(posedge CLK_SYS) disable iff (!RST_N)
        LEDS_OFF |-> DISPLAY_BLANK && q.cfg[CFG_FOLLOW];
    endproperty
    a_leds: assert property (p_leds)
        else $error("leds off without follow host");

    // hold mode never passes eight seconds
    property p_hold_max;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.st == ST_PONP && q.plen == PLEN_HOLD |-> q.pcnt <= MAX_HOLD_TK;
    endproperty
    a_hold_max: assert property (p_hold_max)
        else $error("hold pulse exceeded limit");

    // watchdog off after every self restart
    property p_wd_off;
        @(posedge CLK_SYS) disable iff (!RST_N)
        SELF_RESTART |-> q.wd_to == 8'h00 && q.st == ST_IDLE;
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("watchdog survived restart");

    // tick is a single-cycle pulse
    property p_tick;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.tick |=> !q.tick;
    endproperty
    a_tick: assert property (p_tick)
        else $error("tick longer than one cycle");

    // released key clears hold timer
    property p_hold_clr;
        @(posedge CLK_SYS) disable iff (!RST_N)
        !q.stab[IN_CONF] |=> q.conf_cnt == 9'h000;
    endproperty
    a_hold_clr: assert property (p_hold_clr)
        else $error("hold timer kept after release");

endmodule : hpsc_top

// ===== core/hpsc_pkg.sv
// Purpose: constants and types shared by the host power switch controller
// Assumes: 25 MHz system clock, 1/32 second base tick
// Notes: counts derived from times in their own units
package hpsc_pkg;

    // clock and tick base
    localparam int CLK_HZ = 25_000_000;
    localparam int TICKS_PER_S = 32;
    localparam int TICK_CYCLES_DEF = CLK_HZ / TICKS_PER_S;

    // hold and pulse times in milliseconds
    localparam int HOLD_LONG_MS = 4000;
    localparam int HOLD_SHORT_MS = 250;
    localparam int RST_PULSE_MS = 1000;
    localparam int EXT_HOLD_MS = 5000;
    localparam int MAX_HOLD_MS = 8000;

    // the same times as tick counts (least times round up)
    localparam logic [8:0] HOLD_LONG_TK =
        9'((HOLD_LONG_MS * TICKS_PER_S + 999) / 1000);
    localparam logic [8:0] HOLD_SHORT_TK =
        9'((HOLD_SHORT_MS * TICKS_PER_S + 999) / 1000);
    localparam logic [8:0] RST_PULSE_TK =
        9'((RST_PULSE_MS * TICKS_PER_S) / 1000);
    localparam logic [8:0] EXT_HOLD_TK =
        9'((EXT_HOLD_MS * TICKS_PER_S) / 1000);
    localparam logic [8:0] MAX_HOLD_TK =
        9'((MAX_HOLD_MS * TICKS_PER_S) / 1000);

    // packet types
    localparam logic [7:0] CMD_ATX = 8'h1C;
    localparam logic [7:0] RSP_ATX = 8'h5C;
    localparam logic [7:0] CMD_WDOG = 8'h1D;
    localparam logic [7:0] RSP_WDOG = 8'h5D;
    localparam logic [7:0] RSP_ERR = 8'hC0;

    // register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_RESP = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0C;

    // function bitmask positions
    localparam int CFG_AUTO = 0;
    localparam int CFG_RINV = 1;
    localparam int CFG_PINV = 2;
    localparam int CFG_LEDS = 3;
    localparam int CFG_FOLLOW = 4;
    localparam int CFG_KRST = 5;
    localparam int CFG_KON = 6;
    localparam int CFG_KOFF = 7;

    // values after reset
    localparam logic [7:0] BOOT_CFG_RST = 8'h01;
    localparam logic [7:0] PLEN_HOLD = 8'hFF;

    // synchronised input positions
    localparam int IN_SENSE = 0;
    localparam int IN_CONF = 1;
    localparam int IN_CANC = 2;
    localparam int IN_RSTL = 3;
    localparam int IN_PWRL = 4;

    // message codes
    localparam logic [1:0] MSG_NONE = 2'h0;
    localparam logic [1:0] MSG_RESTART = 2'h1;
    localparam logic [1:0] MSG_PWR_ON = 2'h2;
    localparam logic [1:0] MSG_PWR_OFF = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RSTP = 5'b00010,
        ST_PONP = 5'b00100,
        ST_POFFP = 5'b01000,
        ST_POFFX = 5'b10000
    } hpsc_state_e;

    typedef struct packed {
        hpsc_state_e st;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] stab;
        logic sense_prev;
        logic sense_at;
        logic [19:0] tick_cnt;
        logic tick;
        logic [7:0] cfg;
        logic [7:0] plen;
        logic [7:0] boot_cfg;
        logic [7:0] boot_plen;
        logic [7:0] wd_to;
        logic [7:0] wd_cnt;
        logic [4:0] wd_sub;
        logic [8:0] conf_cnt;
        logic [8:0] canc_cnt;
        logic [8:0] pcnt;
        logic rst_idle;
        logic pwr_idle;
        logic rst_lvl;
        logic pwr_lvl;
        logic rst_oe;
        logic pwr_oe;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] resp_type;
        logic [1:0] resp_len;
        logic [7:0] resp_d0;
        logic [7:0] resp_d1;
        logic resp_vld;
        logic self_rst;
        logic blank;
        logic leds_off;
        logic [1:0] msg;
    } hpsc_regs_s;

endpackage : hpsc_pkg

// ===== test/hpsc_host.sv
// Purpose: host side model, pull-ups on both lines and a host supply
// Assumes: a power press toggles the host after PRESS_CYC low cycles
// Notes: bench may force the supply state through set_en and set_val
`timescale 1ns/100ps
module hpsc_host #(
    parameter int PRESS_CYC = 32
) (
    // clock
    input wire logic clk,
    // lines from the controller
    input wire logic rst_o,
    input wire logic rst_oe,
    input wire logic pwr_o,
    input wire logic pwr_oe,
    // bench control of the supply
    input wire logic set_en,
    input wire logic set_val,
    // resolved wires and sense
    output logic rst_wire,
    output logic pwr_wire,
    output logic sense
);
    logic [7:0] low_cnt;
    logic on_q;

    // pins left in default function, pull-up wins when released
    assign rst_wire = rst_oe ? rst_o : 1'b1;
    assign pwr_wire = pwr_oe ? pwr_o : 1'b1;
    assign sense = on_q;

    // supply toggles once per long enough low press
    always @(posedge clk) begin
        if (set_en) begin
            on_q <= set_val;
        end else if (low_cnt == 8'(PRESS_CYC)) begin
            on_q <= !on_q;
        end
        if (pwr_wire) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
endmodule : hpsc_host

// ===== test/hpsc_test.sv
// Purpose: self-checking bench for the host power switch controller
// Assumes: tick of 4 cycles, host model with pull-ups on both lines
// Notes: random config bytes come from an xorshift generator
`timescale 1ns/100ps
module hpsc_test
    import hpsc_pkg::*;
();
    localparam int TK = 4;
    localparam int LIMIT = 20000;
    logic clk, rst_n, cyc, stb, we, ack, conf, canc, set_en, set_val;
    logic r_o, r_oe, p_o, p_oe, r_w, p_w, sense;
    logic blank, bl_off, leds_off, self_rst;
    logic [1:0] msg;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, dat_o, rdat, seed;
    int fail_count, checked, cycles, sr_seen;

    // device and host side
    hpsc_top #(.TICK_CYCLES(TK)) DUT (.CLK_SYS(clk), .RST_N(rst_n),
        .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .POWER_SENSE(sense), .KEY_CONFIRM(conf), .KEY_CANCEL(canc),
        .RESTART_I(r_w), .RESTART_O(r_o), .RESTART_OE(r_oe),
        .POWER_CTL_I(p_w), .POWER_CTL_O(p_o), .POWER_CTL_OE(p_oe),
        .DISPLAY_BLANK(blank), .BACKLIGHT_OFF(bl_off),
        .LEDS_OFF(leds_off), .MESSAGE(msg), .SELF_RESTART(self_rst));
    hpsc_host u_host (.clk(clk), .rst_o(r_o), .rst_oe(r_oe), .pwr_o(p_o),
        .pwr_oe(p_oe), .set_en(set_en), .set_val(set_val),
        .rst_wire(r_w), .pwr_wire(p_w), .sense(sense));

    // clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // cycle ceiling and self restart counter
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (self_rst === 1'b1) begin
            sr_seen <= sr_seen + 1;
        end
        if (cycles == LIMIT) begin
            fail_count = fail_count + 1;
            finish_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s exp %h seen %h", s, exp, seen);
        end
    endtask : check

    task automatic near(string s, int v, int lo, int hi);
        check(s, v >= lo && v <= hi, 32'h1);
    endtask : near

    // one classic cycle, held until ack is sampled high
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        check("ack", ack, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic cmd(logic [7:0] t, logic [1:0] n, logic [7:0] a, b);
        wb(1'b1, REG_CMD, {b, a, 6'h00, n, t});
        wb(1'b0, REG_RESP, 32'h0);
    endtask : cmd

    // response compare on the bytes its length covers
    task automatic exp_rsp(string s, logic [7:0] t, logic [1:0] n,
                           logic [7:0] a, logic [7:0] b);
        logic [31:0] m;
        m = n == 2'd0 ? 32'h7FF : (n == 2'd1 ? 32'hFF07FF : 32'hFFFF07FF);
        check(s, rdat & m, {b, a, 5'h00, 1'b1, n, t} & m);
    endtask : exp_rsp

    task automatic host(logic v);
        @(posedge clk);
        set_en <= 1'b1;
        set_val <= v;
        @(posedge clk);
        set_en <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : host

    task automatic quiet(int n);
        int k;
        k = 0;
        repeat (n) begin
            @(posedge clk);
            if (r_oe !== 1'b0 || p_oe !== 1'b0) k++;
        end
        check("quiet", k, 32'h0);
    endtask : quiet

    // wait for a pulse, check it, time it in ticks, drop keys at rel
    task automatic pulse(logic pwr, int lim, int rel, int lvl, int m,
                         output int t0, output int len);
        t0 = 0;
        len = 0;
        while ((pwr ? p_oe : r_oe) !== 1'b1 && t0 < lim) begin
            @(posedge clk);
            t0++;
        end
        check("drive", pwr ? p_oe : r_oe, 32'h1);
        check("level", pwr ? p_o : r_o, lvl[0]);
        if (m >= 0) check("message", msg, m[1:0]);
        while ((pwr ? p_oe : r_oe) === 1'b1 && len < 2000) begin
            @(posedge clk);
            len++;
            if (len == rel) begin
                conf <= 1'b0;
                canc <= 1'b0;
            end
        end
        check("release", {r_oe, p_oe}, 32'h0);
        len = (len + 2) / TK;
    endtask : pulse

    task automatic finish_test();
        $display("checks %0d fails %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        int t0, len, s0;
        logic [7:0] m, p;
        seed = 32'h7240;
        {fail_count, checked} = '0;
        {rst_n, cyc, stb, we, conf, canc, set_val} = '0;
        set_en = 1'b1;
        sel = 4'hF;
        adr = 8'h00;
        wdat = 32'h0;
        repeat (3) @(posedge clk);
        check("reset", {r_oe, p_oe, ack, self_rst}, 32'h0);
        rst_n <= 1'b1;
        set_val <= 1'b1;
        repeat (4) @(posedge clk);
        cmd(CMD_ATX, 2'd0, 8'h00, 8'h00);
        exp_rsp("cfg", RSP_ATX, 2'd2, BOOT_CFG_RST, PLEN_HOLD);
        cmd(CMD_WDOG, 2'd0, 8'h00, 8'h00);
        exp_rsp("wdog", RSP_WDOG, 2'd1, 8'h00, 8'h00);
        cmd(8'h06, 2'd0, 8'h00, 8'h00);
        exp_rsp("bad type", RSP_ERR | 8'h06, 2'd0, 8'h00, 8'h00);
        wb(1'b1, 8'h40, rnd());
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped", rdat, 32'h0);
        for (int i = 0; i < 3; i++) begin
            m = 8'(rnd());
            p = 8'(rnd());
            cmd(CMD_ATX, 2'd2, m, p);
            exp_rsp("cfg wr", RSP_ATX, 2'd0, 8'h00, 8'h00);
            cmd(CMD_ATX, 2'd0, 8'h00, 8'h00);
            exp_rsp("cfg rd", RSP_ATX, 2'd2, m, p);
        end
        // module follows host
        cmd(CMD_ATX, 2'd1, 8'h18, 8'h00);
        cmd(CMD_ATX, 2'd0, 8'h00, 8'h00);
        exp_rsp("cfg one", RSP_ATX, 2'd2, 8'h18, p);
        host(1'b0);
        check("blank", {blank, bl_off, leds_off}, 32'h7);
        cmd(CMD_ATX, 2'd1, 8'h10, 8'h00);
        repeat (2) @(posedge clk);
        check("leds", {blank, leds_off}, 32'h2);
        s0 = sr_seen;
        host(1'b1);
        check("follow", sr_seen - s0, 32'h1);
        check("unblank", blank, 32'h0);
        // keyboard power on, boot state stored first
        host(1'b0);
        cmd(CMD_ATX, 2'd1, 8'h41, 8'h00);
        wb(1'b1, REG_CTRL, 32'h1);
        s0 = sr_seen;
        conf <= 1'b1;
        pulse(1'b1, 100, 0, 0, MSG_PWR_ON, t0, len);
        conf <= 1'b0;
        near("on hold", t0, 32, 44);
        near("on len", len, 8, 12);
        repeat (6) @(posedge clk);
        check("on self", sr_seen - s0, 32'h1);
        cmd(CMD_ATX, 2'd0, 8'h00, 8'h00);
        exp_rsp("boot", RSP_ATX, 2'd2, 8'h41, PLEN_HOLD);
        // keyboard restart, short hold first
        cmd(CMD_ATX, 2'd1, 8'h22, 8'h00);
        conf <= 1'b1;
        quiet(400);
        conf <= 1'b0;
        quiet(8);
        conf <= 1'b1;
        s0 = sr_seen;
        fork
            pulse(1'b0, 700, 0, 1, MSG_RESTART, t0, len);
            begin
                repeat (560) @(posedge clk);
                cmd(CMD_ATX, 2'd0, 8'h00, 8'h00);
            end
        join
        conf <= 1'b0;
        check("ignored", rdat[10], 32'h0);
        near("rst hold", t0, 512, 524);
        near("rst len", len, 32, 34);
        repeat (4) @(posedge clk);
        check("rst self", sr_seen - s0, 32'h1);
        // keyboard power off, released early and held past the limit
        cmd(CMD_ATX, 2'd2, 8'h84, 8'h04);
        for (int i = 0; i < 2; i++) begin
            canc <= 1'b1;
            pulse(1'b1, 600, i ? 800 : 160, 1, MSG_PWR_OFF, t0, len);
            canc <= 1'b0;
            near("off hold", t0, 512, 524);
            near("off len", len, i ? 164 : 40, i ? 167 : 43);
            quiet(8);
        end
        // watchdog expiry, then stays off
        cmd(CMD_WDOG, 2'd1, 8'h01, 8'h00);
        exp_rsp("wd set", RSP_WDOG, 2'd0, 8'h00, 8'h00);
        cmd(CMD_WDOG, 2'd0, 8'h00, 8'h00);
        exp_rsp("wd read", RSP_WDOG, 2'd1, 8'h01, 8'h00);
        s0 = sr_seen;
        pulse(1'b0, 200, 0, 0, -1, t0, len);
        near("wd time", t0, 100, 132);
        near("wd len", len, 32, 34);
        repeat (4) @(posedge clk);
        check("wd self", sr_seen - s0, 32'h1);
        cmd(CMD_WDOG, 2'd0, 8'h00, 8'h00);
        exp_rsp("wd off", RSP_WDOG, 2'd1, 8'h00, 8'h00);
        quiet(300);
        cmd(CMD_WDOG, 2'd1, 8'h02, 8'h00);
        cmd(CMD_WDOG, 2'd1, 8'h00, 8'h00);
        quiet(400);
        finish_test();
    end
endmodule : hpsc_test
